// ### core/pcbs_lane_merge.sv
// Byte-lane write merge: applies byte enables and a writable-bit mask.
// Assumes data and enables arrive on the same clock as the register.
`timescale 1ns/1ps
`default_nettype none
module pcbs_lane_merge
(
  input wire logic [31:0] old_value,
  input wire logic [31:0] wr_data,
  input wire logic [3:0] wr_be,
  input wire logic [31:0] writable_mask,
  output logic [31:0] merged
);
  // ---------------------------------------------------------------------------
  // Lane merge
  // ---------------------------------------------------------------------------
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1)
    begin : g_lane
      // Only enabled lanes and writable bits take the new value.
      assign merged[lane*8 +: 8] = wr_be[lane] ?
        ((wr_data[lane*8 +: 8] & writable_mask[lane*8 +: 8]) |
         (old_value[lane*8 +: 8] & ~writable_mask[lane*8 +: 8])) :
        old_value[lane*8 +: 8];
    end
  endgenerate
endmodule // pcbs_lane_merge
`default_nettype wire

// ### core/pcbs_pkg.sv
// Package for the configuration window base and subsystem identity registers.
// Assumes a 32-bit configuration data path with four byte enables per side.
package pcbs_pkg;
  // --------------------------------------------------------------------------
  // Register offsets
  // --------------------------------------------------------------------------
  localparam logic [7:0] PCBS_OFF_CSR_MEMORY_WINDOW_BASE = 8'h20;
  localparam logic [7:0] PCBS_OFF_IO_WINDOW_BASE = 8'h24;
  localparam logic [7:0] PCBS_OFF_SUBSYSTEM_IDENT = 8'h2C;
  // --------------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------------
  localparam int PCBS_MEM_BASE_LSB = 24;
  localparam int PCBS_IO_BASE_LSB = 8;
  localparam int PCBS_SUBSYS_DEV_LSB = 16;
  // --------------------------------------------------------------------------
  // Fixed low bits and reset values
  // --------------------------------------------------------------------------
  localparam logic [23:0] PCBS_MEM_LOW_BITS = 24'h000008;
  localparam logic [7:0] PCBS_IO_LOW_BITS = 8'h01;
  localparam logic [7:0] PCBS_MEM_BASE_RESET = 8'h00;
  localparam logic [23:0] PCBS_IO_BASE_RESET = 24'h000000;
  localparam logic [15:0] PCBS_SUBSYS_RESET = 16'h0000;
  localparam logic [31:0] PCBS_RDATA_RESET = 32'h00000000;
  // Side selector type; the shared write-merge helper takes no side input and does not use it.
  typedef enum logic [1:0] {PCBS_SIDE_PCI = 2'b01, PCBS_SIDE_AHB = 2'b10} pcbs_side_t;
endpackage

// ### core/pcbs_regs.sv
// Two window base registers and the subsystem identity register, reachable
// from the PCI configuration side and the internal AHB side.
// Assumes both sides present one-cycle synchronous strobes on mclk.
`timescale 1ns/1ps
`default_nettype none
module pcbs_regs
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic pci_cfg_wr,
  input wire logic pci_cfg_rd,
  input wire logic [7:0] pci_cfg_addr,
  input wire logic [31:0] pci_cfg_wdata,
  input wire logic [3:0] pci_cfg_be,
  output logic [31:0] pci_cfg_rdata,
  input wire logic ahb_cfg_wr,
  input wire logic ahb_cfg_rd,
  input wire logic [7:0] ahb_cfg_addr,
  input wire logic [31:0] ahb_cfg_wdata,
  input wire logic [3:0] ahb_cfg_be,
  output logic [31:0] ahb_cfg_rdata,
  input wire logic [31:0] pci_mem_addr,
  output logic pci_csr_hit,
  output logic [23:0] pci_csr_offset,
  output logic [31:0] io_window_base_value
);
  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  logic [7:0] mem_base_reg;
  logic [7:0] mem_base_next;
  logic [23:0] io_base_reg;
  logic [23:0] io_base_next;
  logic [31:0] subsys_reg;
  logic [31:0] subsys_next;
  logic [31:0] pci_rdata_reg;
  logic [31:0] pci_rdata_next;
  logic [31:0] ahb_rdata_reg;
  logic [31:0] ahb_rdata_next;
  logic [31:0] mem_word;
  logic [31:0] io_word;
  logic [31:0] mem_after_pci;
  logic [31:0] mem_after_ahb;
  logic [31:0] io_after_pci;
  logic [31:0] io_after_ahb;
  logic [31:0] subsys_after_ahb;
  logic [31:0] mem_ahb_old;
  logic [31:0] io_ahb_old;
  logic pci_mem_wr_hit;
  logic ahb_mem_wr_hit;
  logic pci_io_wr_hit;
  logic ahb_io_wr_hit;
  logic ahb_sub_wr_hit;

  // Read value of a register, shared by both sides since both see the same view.
  function automatic logic [31:0] read_word(input logic [7:0] addr,
                                            input logic [31:0] mem_w,
                                            input logic [31:0] io_w,
                                            input logic [31:0] sub_w);
    logic [31:0] value;
    value = 32'h00000000;
    case (addr)
      pcbs_pkg::PCBS_OFF_CSR_MEMORY_WINDOW_BASE: value = mem_w;
      pcbs_pkg::PCBS_OFF_IO_WINDOW_BASE: value = io_w;
      pcbs_pkg::PCBS_OFF_SUBSYSTEM_IDENT: value = sub_w;
      default: value = 32'h00000000;
    endcase
    return value;
  endfunction

  // Assembled words; the fixed low bits are constants so no write can reach them.
  assign mem_word = {mem_base_reg, pcbs_pkg::PCBS_MEM_LOW_BITS};
  assign io_word = {io_base_reg, pcbs_pkg::PCBS_IO_LOW_BITS};
  assign io_window_base_value = io_word;

  // ---------------------------------------------------------------------------
  // Write merges, PCI first and AHB on top
  // ---------------------------------------------------------------------------
  // AHB is applied after PCI, so a same-cycle collision on one lane lets AHB win.
  // Write hits per side and register; a merge result is only used on a hit.
  assign pci_mem_wr_hit = pci_cfg_wr &&
    (pci_cfg_addr == pcbs_pkg::PCBS_OFF_CSR_MEMORY_WINDOW_BASE);
  assign ahb_mem_wr_hit = ahb_cfg_wr &&
    (ahb_cfg_addr == pcbs_pkg::PCBS_OFF_CSR_MEMORY_WINDOW_BASE);
  assign pci_io_wr_hit = pci_cfg_wr && (pci_cfg_addr == pcbs_pkg::PCBS_OFF_IO_WINDOW_BASE);
  assign ahb_io_wr_hit = ahb_cfg_wr && (ahb_cfg_addr == pcbs_pkg::PCBS_OFF_IO_WINDOW_BASE);
  assign ahb_sub_wr_hit = ahb_cfg_wr && (ahb_cfg_addr == pcbs_pkg::PCBS_OFF_SUBSYSTEM_IDENT);
  // The AHB merge starts from the PCI result only when PCI really writes that word;
  // otherwise idle PCI data and enables would leak into an AHB-only write.
  assign mem_ahb_old = pci_mem_wr_hit ? mem_after_pci : mem_word;
  assign io_ahb_old = pci_io_wr_hit ? io_after_pci : io_word;
  pcbs_lane_merge u_mem_pci
  (
    .old_value(mem_word),
    .wr_data(pci_cfg_wdata),
    .wr_be(pci_cfg_be),
    .writable_mask(32'hFF000000),
    .merged(mem_after_pci)
  );
  pcbs_lane_merge u_mem_ahb
  (
    .old_value(mem_ahb_old),
    .wr_data(ahb_cfg_wdata),
    .wr_be(ahb_cfg_be),
    .writable_mask(32'hFF000000),
    .merged(mem_after_ahb)
  );
  pcbs_lane_merge u_io_pci
  (
    .old_value(io_word),
    .wr_data(pci_cfg_wdata),
    .wr_be(pci_cfg_be),
    .writable_mask(32'hFFFFFF00),
    .merged(io_after_pci)
  );
  pcbs_lane_merge u_io_ahb
  (
    .old_value(io_ahb_old),
    .wr_data(ahb_cfg_wdata),
    .wr_be(ahb_cfg_be),
    .writable_mask(32'hFFFFFF00),
    .merged(io_after_ahb)
  );
  pcbs_lane_merge u_sub_ahb
  (
    .old_value(subsys_reg),
    .wr_data(ahb_cfg_wdata),
    .wr_be(ahb_cfg_be),
    .writable_mask(32'hFFFFFFFF),
    .merged(subsys_after_ahb)
  );

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  // Merge outputs are chosen only for the side whose address matches.
  always_comb
  begin
    logic [31:0] mem_tmp;
    logic [31:0] io_tmp;
    mem_tmp = mem_word;
    io_tmp = io_word;
    if (pci_mem_wr_hit)
    begin
      mem_tmp = mem_after_pci;
    end
    if (ahb_mem_wr_hit)
    begin
      mem_tmp = mem_after_ahb;
    end
    if (pci_io_wr_hit)
    begin
      io_tmp = io_after_pci;
    end
    if (ahb_io_wr_hit)
    begin
      io_tmp = io_after_ahb;
    end
    // Only the writable fields are kept; the fixed low bits are rebuilt as constants.
    mem_base_next = mem_tmp[31:pcbs_pkg::PCBS_MEM_BASE_LSB];
    io_base_next = io_tmp[31:pcbs_pkg::PCBS_IO_BASE_LSB];
    // PCI configuration writes never reach the identity register.
    subsys_next = subsys_reg;
    if (ahb_sub_wr_hit)
    begin
      subsys_next = subsys_after_ahb;
    end
    pci_rdata_next = pci_rdata_reg;
    if (pci_cfg_rd)
    begin
      pci_rdata_next = read_word(pci_cfg_addr, mem_word, io_word, subsys_reg);
    end
    ahb_rdata_next = ahb_rdata_reg;
    if (ahb_cfg_rd)
    begin
      ahb_rdata_next = read_word(ahb_cfg_addr, mem_word, io_word, subsys_reg);
    end
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  // All state holds while the clock enable is low.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_base_reg <= pcbs_pkg::PCBS_MEM_BASE_RESET;
      io_base_reg <= pcbs_pkg::PCBS_IO_BASE_RESET;
      subsys_reg <= {pcbs_pkg::PCBS_SUBSYS_RESET, pcbs_pkg::PCBS_SUBSYS_RESET};
      pci_rdata_reg <= pcbs_pkg::PCBS_RDATA_RESET;
      ahb_rdata_reg <= pcbs_pkg::PCBS_RDATA_RESET;
    end
    else if (clk_en)
    begin
      mem_base_reg <= mem_base_next;
      io_base_reg <= io_base_next;
      subsys_reg <= subsys_next;
      pci_rdata_reg <= pci_rdata_next;
      ahb_rdata_reg <= ahb_rdata_next;
    end
  end

  assign pci_cfg_rdata = pci_rdata_reg;
  assign ahb_cfg_rdata = ahb_rdata_reg;

  // ---------------------------------------------------------------------------
  // Memory window decode
  // ---------------------------------------------------------------------------
  // Combinational so the target logic can claim the access in its own cycle.
  assign pci_csr_hit = (pci_mem_addr[31:pcbs_pkg::PCBS_MEM_BASE_LSB] == mem_base_reg);
  assign pci_csr_offset = pci_mem_addr[pcbs_pkg::PCBS_MEM_BASE_LSB-1:0];
endmodule // pcbs_regs
`default_nettype wire

// ### verification/pcbs_host_model.sv
// Model of the configuration master and the internal processor.
// Assumes the bench calls acc; one access at a time on either side.
`timescale 1ns/1ps
`default_nettype none
module pcbs_host_model
(
  input wire logic mclk,
  output logic pci_wr,
  output logic pci_rd,
  output logic ahb_wr,
  output logic ahb_rd,
  output logic [7:0] addr,
  output logic [31:0] wdata,
  output logic [3:0] be,
  input wire logic [31:0] pci_rdata,
  input wire logic [31:0] ahb_rdata
);
  // ----------------------------------------------------------------------
  // Access task
  // ----------------------------------------------------------------------
  initial {pci_wr, pci_rd, ahb_wr, ahb_rd, addr, wdata, be} = '0;
  // One-cycle strobe; afterwards the lines show inverted junk, not old data.
  task automatic acc(input bit side_ahb, input bit wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] b, output logic [31:0] q);
    @(negedge mclk);
    {addr, wdata, be} = {a, d, b};
    {ahb_wr, ahb_rd} = side_ahb ? {wr, !wr} : 2'b00;
    {pci_wr, pci_rd} = side_ahb ? 2'b00 : {wr, !wr};
    @(negedge mclk);
    {pci_wr, pci_rd, ahb_wr, ahb_rd} = 4'h0;
    {addr, wdata, be} = ~{a, d, b};
    q = side_ahb ? ahb_rdata : pci_rdata;
  endtask
endmodule // pcbs_host_model
`default_nettype wire

// ### verification/pcbs_regs_sva.sv
// Checker for the window base registers; the subsystem identity register is not checked.
// Assumes it is bound to pcbs_regs and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module pcbs_regs_sva
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic pci_cfg_rd,
  input wire logic pci_cfg_wr,
  input wire logic [7:0] pci_cfg_addr,
  input wire logic [31:0] pci_cfg_rdata,
  input wire logic ahb_cfg_rd,
  input wire logic ahb_cfg_wr,
  input wire logic [7:0] ahb_cfg_addr,
  input wire logic [31:0] ahb_cfg_wdata,
  input wire logic [3:0] ahb_cfg_be,
  input wire logic [31:0] ahb_cfg_rdata,
  input wire logic [31:0] pci_mem_addr,
  input wire logic [23:0] pci_csr_offset,
  input wire logic [31:0] io_window_base_value
);
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  // All checks share the one clock, and reset masks them.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_mem_low;
    clk_en && pci_cfg_rd && pci_cfg_addr == 8'h20 |=> pci_cfg_rdata[23:0] == 24'h000008;
  endproperty
  a_mem_low: assert property (p_mem_low) else $error("memory window low bits wrong");
  property p_io_low_rd;
    clk_en && ahb_cfg_rd && ahb_cfg_addr == 8'h24 |=> ahb_cfg_rdata[7:0] == 8'h01;
  endproperty
  a_io_low_rd: assert property (p_io_low_rd) else $error("io window low bits wrong");
  property p_offset;
    pci_csr_offset == pci_mem_addr[23:0];
  endproperty
  a_offset: assert property (p_offset) else $error("window offset wrong");
  property p_io_fixed;
    io_window_base_value[7:0] == 8'h01;
  endproperty
  a_io_fixed: assert property (p_io_fixed) else $error("io fixed bits changed");
  property p_io_stable;
    !(clk_en && ((pci_cfg_wr && pci_cfg_addr == 8'h24) || (ahb_cfg_wr && ahb_cfg_addr == 8'h24)))
      |=> $stable(io_window_base_value);
  endproperty
  a_io_stable: assert property (p_io_stable) else $error("io base moved unasked");
  property p_io_wr;
    clk_en && ahb_cfg_wr && ahb_cfg_addr == 8'h24 && ahb_cfg_be[3]
      |=> io_window_base_value[31:24] == $past(ahb_cfg_wdata[31:24]);
  endproperty
  a_io_wr: assert property (p_io_wr) else $error("io base write lost");
  property p_unmapped;
    clk_en && pci_cfg_rd && pci_cfg_addr == 8'h00 |=> pci_cfg_rdata == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rdata_hold;
    !(clk_en && pci_cfg_rd) |=> $stable(pci_cfg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
endmodule // pcbs_regs_sva
bind pcbs_regs pcbs_regs_sva u_sva
(
  .mclk(mclk),
  .rst_n(rst_n),
  .clk_en(clk_en),
  .pci_cfg_rd(pci_cfg_rd),
  .pci_cfg_wr(pci_cfg_wr),
  .pci_cfg_addr(pci_cfg_addr),
  .pci_cfg_rdata(pci_cfg_rdata),
  .ahb_cfg_rd(ahb_cfg_rd),
  .ahb_cfg_wr(ahb_cfg_wr),
  .ahb_cfg_addr(ahb_cfg_addr),
  .ahb_cfg_wdata(ahb_cfg_wdata),
  .ahb_cfg_be(ahb_cfg_be),
  .ahb_cfg_rdata(ahb_cfg_rdata),
  .pci_mem_addr(pci_mem_addr),
  .pci_csr_offset(pci_csr_offset),
  .io_window_base_value(io_window_base_value)
);
`default_nettype wire

// ### verification/pci_cfg_bar_subsys_regs_tb.sv
// Self-checking bench for pcbs_regs.
// Assumes the checker binds itself and the host model drives the strobes.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin mismatches++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end
module pci_cfg_bar_subsys_regs_tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic [31:0] pci_mem_addr = 32'h00000000;
  logic pw, pr, aw, ar, hit;
  logic [7:0] addr;
  logic [31:0] wdata, prd, ard, iov, q;
  logic [3:0] be;
  logic [23:0] offs;
  int mismatches = 0;
  int n_tests = 0;
  always #2 mclk = ~mclk;
  pcbs_host_model host (.mclk(mclk), .pci_wr(pw), .pci_rd(pr), .ahb_wr(aw), .ahb_rd(ar),
    .addr(addr), .wdata(wdata), .be(be), .pci_rdata(prd), .ahb_rdata(ard));
  pcbs_regs dut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .pci_cfg_wr(pw), .pci_cfg_rd(pr),
    .pci_cfg_addr(addr), .pci_cfg_wdata(wdata), .pci_cfg_be(be), .pci_cfg_rdata(prd),
    .ahb_cfg_wr(aw), .ahb_cfg_rd(ar), .ahb_cfg_addr(addr), .ahb_cfg_wdata(wdata),
    .ahb_cfg_be(be), .ahb_cfg_rdata(ard), .pci_mem_addr(pci_mem_addr), .pci_csr_hit(hit),
    .pci_csr_offset(offs), .io_window_base_value(iov));
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Reset words seen from both sides, plus an unmapped hole.
  task automatic t_reset();
    for (int s = 0; s < 2; s++)
    begin
      host.acc(s[0], 1'b0, 8'h20, '0, 4'hF, q); `CHK(q, 32'h00000008)
      host.acc(s[0], 1'b0, 8'h24, '0, 4'hF, q); `CHK(q, 32'h00000001)
      host.acc(s[0], 1'b0, 8'h2C, '0, 4'hF, q); `CHK(q, 32'h00000000)
      host.acc(s[0], 1'b0, 8'h00, '0, 4'hF, q); `CHK(q, 32'h00000000)
    end
    $display("test reset done");
  endtask
  // All-ones writes must leave fixed bits alone; then decode the window.
  task automatic t_mem();
    host.acc(1'b0, 1'b1, 8'h20, 32'hFFFFFFFF, 4'hF, q);
    host.acc(1'b1, 1'b0, 8'h20, '0, 4'hF, q); `CHK(q, 32'hFF000008)
    host.acc(1'b1, 1'b1, 8'h20, 32'h5A0000FF, 4'h8, q);
    host.acc(1'b0, 1'b0, 8'h20, '0, 4'hF, q); `CHK(q, 32'h5A000008)
    pci_mem_addr = 32'h5A123456;
    #1 `CHK({hit, offs}, 25'h1123456)
    @(negedge mclk);
    pci_mem_addr = 32'h5B000000;
    #1 `CHK(hit, 1'b0)
    $display("test mem done");
  endtask
  // Lane-limited write to the I/O base; frozen clock enable blocks writes.
  task automatic t_io();
    host.acc(1'b1, 1'b1, 8'h24, 32'hFFFFFFFF, 4'hB, q);
    host.acc(1'b0, 1'b0, 8'h24, '0, 4'hF, q); `CHK(q, 32'hFF00FF01)
    `CHK(iov, 32'hFF00FF01)
    clk_en = 1'b0;
    host.acc(1'b0, 1'b1, 8'h24, 32'h00000000, 4'hF, q);
    clk_en = 1'b1;
    `CHK(iov, 32'hFF00FF01)
    $display("test io done");
  endtask
  // The processor sets the identity; the configuration side cannot.
  task automatic t_sub();
    host.acc(1'b1, 1'b1, 8'h2C, 32'h12345678, 4'hF, q);
    host.acc(1'b0, 1'b1, 8'h2C, 32'hFFFFFFFF, 4'hF, q);
    host.acc(1'b0, 1'b0, 8'h2C, '0, 4'hF, q); `CHK(q, 32'h12345678)
    host.acc(1'b1, 1'b1, 8'h2C, 32'hABCD0000, 4'hC, q);
    host.acc(1'b1, 1'b0, 8'h2C, '0, 4'hF, q); `CHK(q, 32'hABCD5678)
    $display("test sub done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Watchdog: the tests need well under a thousand cycles.
  initial
  begin
    #20000;
    mismatches++;
    close_out();
  end
  initial
  begin
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    t_reset();
    t_mem();
    t_io();
    t_sub();
    close_out();
  end
endmodule // pci_cfg_bar_subsys_regs_tb
`undef CHK
`default_nettype wire
